/* File: hdl/sbsc_params.svh */
// constants for the sync burst sram control block
`ifndef SBSC_PARAMS_SVH
`define SBSC_PARAMS_SVH
`define SBSC_ADDR_W 4
`define SBSC_HI_W 2
`define SBSC_DEPTH 16
`define SBSC_LANES 4
`define SBSC_LANE_W 9
`define SBSC_DATA_W 36
`define SBSC_BURST_W 2
`define SBSC_WIDE_CFG 1'b1
`define SBSC_LANES_WIDE 4'hf
`define SBSC_LANES_NARROW 4'h3
`define SBSC_SYNC_W 4
`define SBSC_SYNC_OE_N 0
`define SBSC_SYNC_FT 1
`define SBSC_SYNC_LBO 2
`define SBSC_SYNC_ZZ 3
`define SBSC_SYNC_RST 4'h3
`define SBSC_LANE_RST 9'h000
`define SBSC_DATA_RST 36'h0
`define SBSC_BURST_RST 2'h0
`define SBSC_HI_RST 2'h0
`endif

/* File: hdl/sbsc_pkg.sv */
// types for the sync burst sram control block
package sbsc_pkg;
    typedef enum logic [2:0] {
        SBSC_OP_IDLE = 3'b000,
        SBSC_OP_DESEL = 3'b001,
        SBSC_OP_BEGIN_RD = 3'b010,
        SBSC_OP_BEGIN_WR = 3'b011,
        SBSC_OP_CONT = 3'b100,
        SBSC_OP_SUSP = 3'b101
    } sbsc_op_t;
endpackage

/* File: hdl/sbsc_lane.sv */
// one byte lane of flip-flop storage with combinational read
`timescale 1ns/1ps
`include "sbsc_params.svh"
module sbsc_lane #(
    parameter int W = `SBSC_LANE_W,
    parameter int AW = `SBSC_ADDR_W,
    parameter int DEPTH = `SBSC_DEPTH
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic we_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [W-1:0] data_in,
    output logic [W-1:0] data_out
);
    logic [W-1:0] mem_r [DEPTH];

    assign data_out = mem_r[addr_in];

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (we_in) begin
            mem_r[addr_in] <= data_in;
        end
    end
endmodule

/* File: hdl/sbsc_burst_ctr.sv */
// two-bit burst counter with linear or interleaved order
`timescale 1ns/1ps
`include "sbsc_params.svh"
module sbsc_burst_ctr (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic load_in,
    input wire logic step_in,
    input wire logic [`SBSC_BURST_W-1:0] start_in,
    input wire logic interleave_in,
    output logic [`SBSC_BURST_W-1:0] addr_out
);
    logic [`SBSC_BURST_W-1:0] start_r;
    logic [`SBSC_BURST_W-1:0] cnt_r;
    wire [`SBSC_BURST_W-1:0] start_now;
    wire [`SBSC_BURST_W-1:0] offset_nxt;

    // a two-bit offset wraps by itself, so the fifth address is the first
    assign start_now = load_in ? start_in : start_r;
    assign offset_nxt = load_in ? `SBSC_BURST_RST : (step_in ? cnt_r + 2'h1 : cnt_r);
    assign addr_out = interleave_in ? (start_now ^ offset_nxt) : (start_now + offset_nxt);

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            start_r <= `SBSC_BURST_RST;
            cnt_r <= `SBSC_BURST_RST;
        end else begin
            start_r <= start_now;
            cnt_r <= offset_nxt;
        end
    end
endmodule

/* File: hdl/sbsc_top.sv */
// command decode, write control and output drive of the burst sram
//
// Summary of operation
// - all-lanes store high, byte gate low: write lanes whose enables low
// - both write inputs high: read, all lanes
// - writes keep every data lane floated
// - lanes three and four only when wide
// - write indication true for any write code
// - output enable high turns drivers off
// - deselect decode floats data, uses no address
// - read burst start at external address
// - write burst start, data captured
// - strobe high, advance low: next address
// - strobe high, advance high: hold address
// - every input combination decodes to an action
// - dummy read advances counter like a read
// - four-address burst, linear or interleaved, wraps
// - select low flow-through, high pipelined
// - sleep high: standby, contents kept
`timescale 1ns/1ps
`include "sbsc_params.svh"
module sbsc_top (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic [`SBSC_ADDR_W-1:0] addr_in,
    input wire logic [`SBSC_DATA_W-1:0] dq_in,
    input wire logic chip_select_low_a_in,
    input wire logic chip_select_high_in,
    input wire logic chip_select_low_b_in,
    input wire logic cpu_addr_strobe_n_in,
    input wire logic ctrl_addr_strobe_n_in,
    input wire logic burst_step_n_in,
    input wire logic all_lanes_store_n_in,
    input wire logic byte_store_gate_n_in,
    input wire logic lane0_store_n_in,
    input wire logic lane1_store_n_in,
    input wire logic lane2_store_n_in,
    input wire logic lane3_store_n_in,
    input wire logic output_enable_n_in,
    input wire logic output_register_select_in,
    input wire logic burst_order_select_in,
    input wire logic sleep_request_in,
    output logic [`SBSC_DATA_W-1:0] dq_out,
    output logic [`SBSC_LANES-1:0] dq_oe_out,
    output sbsc_pkg::sbsc_op_t op_out,
    output logic write_cycle_out,
    output logic [`SBSC_ADDR_W-1:0] burst_addr_out,
    output logic sleeping_out
);
    // asynchronous mode pins and output enable pass two flops first
    logic [`SBSC_SYNC_W-1:0] sync1_r;
    logic [`SBSC_SYNC_W-1:0] sync2_r;
    wire [`SBSC_SYNC_W-1:0] pins_raw;
    wire oe_n_s;
    wire pipelined_s;
    wire interleave_s;
    wire sleep_s;

    assign pins_raw = {sleep_request_in, burst_order_select_in,
                       output_register_select_in, output_enable_n_in};
    assign oe_n_s = sync2_r[`SBSC_SYNC_OE_N];
    assign pipelined_s = sync2_r[`SBSC_SYNC_FT];
    assign interleave_s = sync2_r[`SBSC_SYNC_LBO];
    assign sleep_s = sync2_r[`SBSC_SYNC_ZZ];

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            sync1_r <= `SBSC_SYNC_RST;
            sync2_r <= `SBSC_SYNC_RST;
        end else begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
        end
    end

    // byte write decode
    wire [`SBSC_LANES-1:0] lane_store_n;
    wire [`SBSC_LANES-1:0] lane_present;
    wire write_ind;
    wire [`SBSC_LANES-1:0] lane_mask;

    assign lane_store_n = {lane3_store_n_in, lane2_store_n_in,
                           lane1_store_n_in, lane0_store_n_in};
    assign lane_present = `SBSC_WIDE_CFG ? `SBSC_LANES_WIDE : `SBSC_LANES_NARROW;
    assign write_ind = !all_lanes_store_n_in || !byte_store_gate_n_in;
    // all lanes enables high with the gate low is a legal write that stores nothing
    assign lane_mask = !all_lanes_store_n_in ? lane_present :
                       (!byte_store_gate_n_in ? (~lane_store_n & lane_present) :
                       {`SBSC_LANES{1'b0}});

    // synchronous command decode
    wire enabled;
    wire do_desel;
    wire do_begin_rd;
    wire do_begin_wr;
    wire do_cont;
    wire do_susp;
    sbsc_pkg::sbsc_op_t op_nxt;

    assign enabled = chip_select_high_in && !chip_select_low_a_in && !chip_select_low_b_in;
    assign do_desel = (!chip_select_low_a_in && !enabled &&
                       (!cpu_addr_strobe_n_in || !ctrl_addr_strobe_n_in)) ||
                      (chip_select_low_a_in && !ctrl_addr_strobe_n_in);
    assign do_begin_rd = enabled && (!cpu_addr_strobe_n_in ||
                         (!ctrl_addr_strobe_n_in && !write_ind));
    assign do_begin_wr = enabled && cpu_addr_strobe_n_in &&
                         !ctrl_addr_strobe_n_in && write_ind;
    assign do_cont = ctrl_addr_strobe_n_in && !burst_step_n_in &&
                     (cpu_addr_strobe_n_in || chip_select_low_a_in);
    assign do_susp = ctrl_addr_strobe_n_in && burst_step_n_in &&
                     (cpu_addr_strobe_n_in || chip_select_low_a_in);

    // the terms above cover every input code; idle is reached only in sleep
    assign op_nxt = sleep_s ? sbsc_pkg::SBSC_OP_IDLE :
                    do_desel ? sbsc_pkg::SBSC_OP_DESEL :
                    do_begin_wr ? sbsc_pkg::SBSC_OP_BEGIN_WR :
                    do_begin_rd ? sbsc_pkg::SBSC_OP_BEGIN_RD :
                    do_cont ? sbsc_pkg::SBSC_OP_CONT :
                    do_susp ? sbsc_pkg::SBSC_OP_SUSP :
                    sbsc_pkg::SBSC_OP_IDLE;

    logic is_load;
    logic is_step;
    logic is_access;
    logic is_write;

    always_comb begin
        is_load = 1'b0;
        is_step = 1'b0;
        is_access = 1'b1;
        is_write = write_ind;
        case (op_nxt)
            sbsc_pkg::SBSC_OP_BEGIN_RD: begin
                is_load = 1'b1;
                is_write = 1'b0;
            end
            sbsc_pkg::SBSC_OP_BEGIN_WR: begin
                is_load = 1'b1;
                is_write = 1'b1;
            end
            sbsc_pkg::SBSC_OP_CONT: begin
                is_step = 1'b1;
            end
            sbsc_pkg::SBSC_OP_SUSP: begin
                is_step = 1'b0;
            end
            default: begin
                is_access = 1'b0;
                is_write = 1'b0;
            end
        endcase
    end

    // burst address: upper bits held from the load, low bits from the counter
    logic [`SBSC_HI_W-1:0] addr_hi_r;
    wire [`SBSC_HI_W-1:0] addr_hi_now;
    wire [`SBSC_BURST_W-1:0] addr_lo_now;
    wire [`SBSC_ADDR_W-1:0] addr_now;

    assign addr_hi_now = is_load ? addr_in[`SBSC_ADDR_W-1:`SBSC_BURST_W] : addr_hi_r;
    assign addr_now = {addr_hi_now, addr_lo_now};

    sbsc_burst_ctr u_ctr (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .load_in(is_load),
        .step_in(is_step),
        .start_in(addr_in[`SBSC_BURST_W-1:0]),
        .interleave_in(interleave_s),
        .addr_out(addr_lo_now)
    );

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            addr_hi_r <= `SBSC_HI_RST;
        end else begin
            addr_hi_r <= addr_hi_now;
        end
    end

    // storage, one lane module each
    wire [`SBSC_LANES-1:0] lane_we;
    wire [`SBSC_DATA_W-1:0] rd_data;

    assign lane_we = (is_access && is_write) ? lane_mask : {`SBSC_LANES{1'b0}};

    genvar g;
    generate
        for (g = 0; g < `SBSC_LANES; g++) begin : g_lane
            sbsc_lane u_lane (
                .clock_in(clock_in),
                .reset_in(reset_in),
                .we_in(lane_we[g]),
                .addr_in(addr_now),
                .data_in(dq_in[g*`SBSC_LANE_W +: `SBSC_LANE_W]),
                .data_out(rd_data[g*`SBSC_LANE_W +: `SBSC_LANE_W])
            );
        end
    endgenerate

    // read path: flow-through drives a cycle after the command,
    // pipeline one cycle later through the data output stage
    logic [`SBSC_DATA_W-1:0] pipe_data_r;
    logic pipe_vld_r;
    wire rd_now;
    wire drive_cut;
    wire drive_vld;
    wire [`SBSC_DATA_W-1:0] out_nxt;
    wire [`SBSC_LANES-1:0] oe_nxt;

    // a dummy read is an ordinary read whose drivers stay off
    assign rd_now = is_access && !is_write;
    // deselect, write or sleep cut a pending pipelined read at once
    assign drive_cut = (op_nxt == sbsc_pkg::SBSC_OP_DESEL) || is_write || sleep_s;
    assign drive_vld = pipelined_s ? (pipe_vld_r && !drive_cut) : rd_now;
    assign out_nxt = pipelined_s ? pipe_data_r : rd_data;
    // output enable is sampled, so release lags the pin by the synchroniser
    assign oe_nxt = (drive_vld && !oe_n_s) ? lane_present : {`SBSC_LANES{1'b0}};

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            pipe_data_r <= `SBSC_DATA_RST;
            pipe_vld_r <= 1'b0;
            dq_out <= `SBSC_DATA_RST;
            dq_oe_out <= {`SBSC_LANES{1'b0}};
        end else begin
            pipe_data_r <= rd_data;
            pipe_vld_r <= rd_now;
            dq_out <= out_nxt;
            dq_oe_out <= oe_nxt;
        end
    end

    // status outputs
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            op_out <= sbsc_pkg::SBSC_OP_IDLE;
            write_cycle_out <= 1'b0;
            burst_addr_out <= {`SBSC_ADDR_W{1'b0}};
            sleeping_out <= 1'b0;
        end else begin
            op_out <= op_nxt;
            write_cycle_out <= is_access && is_write;
            burst_addr_out <= addr_now;
            sleeping_out <= sleep_s;
        end
    end

    // checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    AST_BYTE_WRITE_LANES: assert property (
        (is_access && is_write && all_lanes_store_n_in && !byte_store_gate_n_in)
        |-> (lane_we == (~lane_store_n & lane_present)))
        else $error("byte write lanes do not follow lane enables");

    AST_ALL_LANES_WRITE: assert property (
        (is_access && is_write && !all_lanes_store_n_in) |-> (lane_we == lane_present))
        else $error("all-lanes write did not store every lane");

    AST_WRITE_FLOATS: assert property (
        write_cycle_out |-> (dq_oe_out == {`SBSC_LANES{1'b0}}))
        else $error("data driven during a write cycle");

    AST_ENABLE_BEGIN: assert property (
        (op_nxt == sbsc_pkg::SBSC_OP_BEGIN_WR || op_nxt == sbsc_pkg::SBSC_OP_BEGIN_RD)
        |-> (chip_select_high_in && !chip_select_low_a_in && !chip_select_low_b_in))
        else $error("burst begun while not enabled");

    AST_OE_OFF: assert property (
        (oe_n_s ##1 oe_n_s) |-> (dq_oe_out == {`SBSC_LANES{1'b0}}))
        else $error("drivers on with output enable high");

    AST_DESEL_FLOAT: assert property (
        (op_out == sbsc_pkg::SBSC_OP_DESEL) |-> (dq_oe_out == {`SBSC_LANES{1'b0}}))
        else $error("data driven in deselect");

    AST_CPU_STROBE_READ: assert property (
        (!sleep_s && enabled && !cpu_addr_strobe_n_in)
        |=> (op_out == sbsc_pkg::SBSC_OP_BEGIN_RD && !write_cycle_out))
        else $error("processor strobe did not start a read burst");

    AST_BURST_STEP: assert property (
        (op_out != sbsc_pkg::SBSC_OP_IDLE && op_out != sbsc_pkg::SBSC_OP_DESEL &&
         op_nxt == sbsc_pkg::SBSC_OP_CONT && !interleave_s && !$changed(interleave_s))
        |=> (burst_addr_out[1:0] == $past(burst_addr_out[1:0]) + 2'h1))
        else $error("linear burst did not step by one");

    AST_BURST_HOLD: assert property (
        (op_nxt == sbsc_pkg::SBSC_OP_SUSP) |=> (burst_addr_out == $past(burst_addr_out)))
        else $error("suspend moved the burst address");

    AST_FLOW_READ: assert property (
        (!pipelined_s && rd_now && !oe_n_s) |=> (dq_oe_out == lane_present))
        else $error("flow-through read not driven next cycle");

    COV_WRITE_BURST: cover property (
        op_out == sbsc_pkg::SBSC_OP_BEGIN_WR ##1 op_out == sbsc_pkg::SBSC_OP_CONT);
    COV_READ_WRAP: cover property (
        op_out == sbsc_pkg::SBSC_OP_BEGIN_RD ##1 op_out == sbsc_pkg::SBSC_OP_CONT [*4]);
    COV_DUMMY_TO_WRITE: cover property (
        (rd_now && oe_n_s) ##1 (op_nxt == sbsc_pkg::SBSC_OP_BEGIN_WR));
    COV_SLEEP: cover property (sleeping_out ##1 !sleeping_out);
endmodule

/* File: bench/sbsc_host_bus.sv */
// host side of the shared data bus: resolves each lane between device and host
`timescale 1ns/1ps
`include "sbsc_params.svh"
module sbsc_host_bus (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic drive_in,
    input wire logic [`SBSC_DATA_W-1:0] data_in,
    input wire logic [`SBSC_DATA_W-1:0] dq_in,
    input wire logic [`SBSC_LANES-1:0] dq_oe_in,
    output logic [`SBSC_DATA_W-1:0] bus_out
);
    logic [`SBSC_DATA_W-1:0] last_r;
    logic [`SBSC_LANES-1:0] host_oe;
    // host holds write data back on any lane the device still drives
    assign host_oe = drive_in ? ~dq_oe_in : 4'h0;
    always_comb begin
        for (int i = 0; i < `SBSC_LANES; i++) begin
            if (dq_oe_in[i])
                bus_out[9*i +: 9] = dq_in[9*i +: 9];
            else if (host_oe[i])
                bus_out[9*i +: 9] = data_in[9*i +: 9];
            else
                bus_out[9*i +: 9] = ~last_r[9*i +: 9];
        end
    end
    // no pull on these lines: an unowned lane toggles so stale data never matches
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in)
            last_r <= 36'h0;
        else
            last_r <= bus_out;
    end
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the sync burst sram control block
`timescale 1ns/1ps
`include "sbsc_params.svh"
module testbench;
    // control order: sel_low_a, sel_high, sel_low_b, cpu, ctrl, step, all_lanes, gate
    localparam logic [7:0] RD = 8'b01001111;
    localparam logic [7:0] WR_ALL = 8'b01010101;
    localparam logic [7:0] WR_BYTE = 8'b01010110;
    localparam logic [7:0] CONT = 8'b01011011;
    localparam logic [7:0] SUSP = 8'b01011111;
    localparam logic [7:0] DESEL = 8'b11010111;
    logic clock_in, reset_in, drive, oe_n, ft_sel, burst_order_select, sleep, wcyc, sleeping;
    logic [7:0] ctl;
    logic [3:0] lanes, addr, dq_oe, baddr;
    logic [35:0] hdata, bus, dq_out;
    sbsc_pkg::sbsc_op_t op;
    logic [35:0] exp_mem [16];
    logic [15:0] rows [12];
    int bad_count, n_checks;
    sbsc_top sbsc_top_inst (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .addr_in(addr),
        .dq_in(bus),
        .chip_select_low_a_in(ctl[7]),
        .chip_select_high_in(ctl[6]),
        .chip_select_low_b_in(ctl[5]),
        .cpu_addr_strobe_n_in(ctl[4]),
        .ctrl_addr_strobe_n_in(ctl[3]),
        .burst_step_n_in(ctl[2]),
        .all_lanes_store_n_in(ctl[1]),
        .byte_store_gate_n_in(ctl[0]),
        .lane0_store_n_in(lanes[0]),
        .lane1_store_n_in(lanes[1]),
        .lane2_store_n_in(lanes[2]),
        .lane3_store_n_in(lanes[3]),
        .output_enable_n_in(oe_n),
        .output_register_select_in(ft_sel),
        .burst_order_select_in(burst_order_select),
        .sleep_request_in(sleep),
        .dq_out(dq_out),
        .dq_oe_out(dq_oe),
        .op_out(op),
        .write_cycle_out(wcyc),
        .burst_addr_out(baddr),
        .sleeping_out(sleeping)
    );
    sbsc_host_bus sbsc_host_bus_inst (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .drive_in(drive),
        .data_in(hdata),
        .dq_in(dq_out),
        .dq_oe_in(dq_oe),
        .bus_out(bus)
    );
    task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] want);
        n_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic tick();
        @(posedge clock_in);
        @(negedge clock_in);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] c, input logic [3:0] m,
                      input logic [35:0] d);
        ctl = c;
        addr = a;
        lanes = m;
        hdata = d;
        drive = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (!c[1] || !m[i])
                exp_mem[a][9*i +: 9] = d[9*i +: 9];
        end
        tick();
        drive = 1'b0;
        lanes = 4'hf;
        chk("op", op, sbsc_pkg::SBSC_OP_BEGIN_WR);
        chk("oe", dq_oe, 4'h0);
    endtask
    task automatic rd(input logic [3:0] a);
        ctl = RD;
        addr = a;
        tick();
        chk("op", op, sbsc_pkg::SBSC_OP_BEGIN_RD);
        chk("oe", dq_oe, 4'hf);
        chk("data", bus, exp_mem[a]);
        ctl = DESEL;
        tick();
    endtask
    task automatic burst(input logic [3:0] a, input logic il);
        logic [1:0] o;
        // a write code left on the pins would keep storing bus noise while waiting
        ctl = DESEL;
        burst_order_select = il;
        repeat (3) tick();
        ctl = RD;
        addr = a;
        tick();
        for (int k = 1; k <= 5; k++) begin
            ctl = (k < 5) ? CONT : SUSP;
            o = 2'((k < 5) ? k : 4);
            o = il ? (a[1:0] ^ o) : (a[1:0] + o);
            tick();
            chk("baddr", baddr, {a[3:2], o});
            chk("data", bus, exp_mem[{a[3:2], o}]);
        end
        ctl = DESEL;
        tick();
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    initial begin
        reset_in = 1'b1;
        ctl = DESEL;
        lanes = 4'hf;
        addr = 4'h0;
        hdata = 36'h0;
        drive = 1'b0;
        oe_n = 1'b0;
        ft_sel = 1'b0;
        burst_order_select = 1'b0;
        sleep = 1'b0;
        rows = '{{8'b01110111, 3'h1, 1'b0, 4'h0}, {8'b00000111, 3'h1, 1'b0, 4'h0},
                 {8'b11010111, 3'h1, 1'b0, 4'h0}, {8'b10001111, 3'h5, 1'b0, 4'hf},
                 {8'b01001101, 3'h2, 1'b0, 4'hf}, {8'b01010111, 3'h2, 1'b0, 4'hf},
                 {8'b01010101, 3'h3, 1'b1, 4'h0}, {8'b01010110, 3'h3, 1'b1, 4'h0},
                 {8'b10011011, 3'h4, 1'b0, 4'hf}, {8'b10001001, 3'h4, 1'b1, 4'h0},
                 {8'b01011100, 3'h5, 1'b1, 4'h0}, {8'b00111011, 3'h4, 1'b0, 4'hf}};
        repeat (8) tick();
        chk("rst", {dq_out[15:0], dq_oe, baddr, op, wcyc, sleeping}, 36'h0);
        reset_in = 1'b0;
        repeat (3) tick();
        foreach (rows[i]) begin
            ctl = rows[i][15:8];
            tick();
            chk("op", op, rows[i][7:5]);
            chk("wcyc", wcyc, rows[i][4]);
            chk("oe", dq_oe, rows[i][3:0]);
        end
        // the last row was a read: its drivers must be off before write data goes on
        ctl = DESEL;
        tick();
        wr(4'h3, WR_ALL, 4'hf, 36'h0);
        for (int m = 0; m < 16; m++) begin
            wr(4'h3, WR_BYTE, 4'(m), {4{5'h15, 4'(m)}});
            rd(4'h3);
        end
        wr(4'h3, 8'b01010100, 4'hf, 36'h9_abcd_ef01);
        rd(4'h3);
        for (int a = 8; a < 12; a++)
            wr(4'(a), WR_ALL, 4'hf, {4{9'(a * 37)}});
        burst(4'h9, 1'b0);
        burst(4'h9, 1'b1);
        // dummy read: drivers stay off but the counter still steps
        burst_order_select = 1'b0;
        oe_n = 1'b1;
        repeat (3) tick();
        ctl = RD;
        addr = 4'h9;
        tick();
        chk("oe", dq_oe, 4'h0);
        ctl = CONT;
        tick();
        chk("baddr", baddr, 4'ha);
        wr(4'ha, WR_ALL, 4'hf, 36'h5_a5a5_a5a5);
        ctl = DESEL;
        oe_n = 1'b0;
        ft_sel = 1'b1;
        repeat (3) tick();
        ctl = RD;
        addr = 4'h8;
        tick();
        addr = 4'ha;
        tick();
        chk("pipe", bus, exp_mem[8]);
        ctl = DESEL;
        sleep = 1'b1;
        repeat (3) tick();
        chk("sleep", sleeping, 1'b1);
        ctl = WR_ALL;
        addr = 4'h8;
        drive = 1'b1;
        tick();
        chk("op", op, sbsc_pkg::SBSC_OP_IDLE);
        drive = 1'b0;
        ctl = DESEL;
        sleep = 1'b0;
        ft_sel = 1'b0;
        repeat (3) tick();
        rd(4'h8);
        rd(4'ha);
        reset_in = 1'b1;
        tick();
        chk("rst_op", op, sbsc_pkg::SBSC_OP_IDLE);
        reset_in = 1'b0;
        foreach (exp_mem[i])
            exp_mem[i] = 36'h0;
        repeat (3) tick();
        rd(4'h9);
        conclude();
    end
endmodule
